// [verilog/pfb_pkg.sv]
// Purpose: Shared constants and types for program flow and I/O bus block
// Assumes: One processor clock, one machine cycle per clock
// Notes: Status word bit positions are fixed here only
package pfb_pkg;
  localparam int PC_W = 12;
  localparam int DATA_W = 16;
  localparam int PORT_W = 3;
  localparam int STK_DEPTH = 4;
  localparam int RAM_AW = 8;
  localparam int OFS_W = 7;
  localparam int FIFO_DEPTH = 8;
  localparam logic [PC_W-1:0] RESET_VEC = 12'h000;
  localparam logic [PC_W-1:0] INTR_VEC = 12'h002;
  localparam logic [PC_W-1:0] PC_STEP = 12'h001;
  localparam logic [RAM_AW-1:0] PAGE1_BASE = 8'h80;
  localparam logic [3:0] PAGE1_MASK = 4'hF;
  // Status word layout as stored by a save
  localparam int SW_OV = 15;
  localparam int SW_OVM = 14;
  localparam int SW_IRQ_MASK_BIT = 13;
  localparam int SW_ARP = 8;
  localparam int SW_DP = 0;
  localparam logic [DATA_W-1:0] SW_UNUSED = 16'h1EFE;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_BRANCH = 5'h01, OP_BRANCH_OV = 5'h02,
    OP_CALL = 5'h03, OP_RET = 5'h04, OP_INTR = 5'h05,
    OP_PUSH = 5'h06, OP_POP = 5'h07, OP_SST_DIR = 5'h08,
    OP_SST_IND = 5'h09, OP_LST = 5'h0A, OP_IRQ_UNMASK_OP = 5'h0B,
    OP_IRQ_MASK_OP = 5'h0C, OP_SET_SATURATION_OP = 5'h0D, OP_CLEAR_SATURATION_OP = 5'h0E,
    OP_ARP_LOAD = 5'h0F, OP_PAGE_LOAD = 5'h10, OP_IN = 5'h11,
    OP_OUT = 5'h12, OP_TABLE_READ_OP = 5'h13, OP_TABLE_WRITE_OP = 5'h14
  } pfb_op_t;

  typedef enum logic [5:0] {
    ST_RUN = 6'h01, ST_IN = 6'h02, ST_OUT = 6'h04,
    ST_TRD = 6'h08, ST_TWR = 6'h10, ST_REF = 6'h20
  } pfb_state_t;
endpackage : pfb_pkg

// [verilog/pfb_stream_if.sv]
// Purpose: Valid/ready word stream between block internals
// Assumes: Single clock domain
// Notes: Width follows the carried data
`timescale 1ns/1ns
`default_nettype none
interface pfb_stream_if #(parameter int WIDTH = 16);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : pfb_stream_if
`default_nettype wire

// [verilog/pfb_fifo.sv]
// Purpose: Small synchronous FIFO for words read from the bus
// Assumes: Shares clock and synchronous active-low reset with its user
// Notes: Read data comes from a register; one word look-ahead
`timescale 1ns/1ns
`default_nettype none
module pfb_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  pfb_stream_if.snk in_s,
  pfb_stream_if.src out_s
);
  import pfb_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [WIDTH-1:0] out_data_reg;
  logic out_valid_reg;
  logic do_wr;
  logic do_rd;
  logic load_out;

  // Output register counts as a slot, so at most DEPTH words are held
  assign in_s.ready = ((count_reg + (AW+1)'(out_valid_reg)) != (AW+1)'(DEPTH));
  assign do_wr = in_s.valid && in_s.ready;
  // Output register refills whenever empty or being taken
  assign load_out = (!out_valid_reg || out_s.ready) && (count_reg != '0);
  assign do_rd = load_out;
  assign out_s.valid = out_valid_reg;
  assign out_s.data = out_data_reg;

  always_ff @(posedge core_clk_i) begin
    if (do_wr) begin
      mem_reg[wr_ptr_reg] <= in_s.data;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (do_rd) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else if (load_out) begin
      out_valid_reg <= 1'b1;
      out_data_reg <= mem_reg[rd_ptr_reg];
    end else if (out_s.ready) begin
      out_valid_reg <= 1'b0;
    end
  end
endmodule : pfb_fifo
`default_nettype wire

// [verilog/pfb_top.sv]
// Purpose: Program counter, return stack, status word and external bus sequencing
// Assumes: Core decodes instructions and hands one command per taken cycle
// Notes: Data bus pin split into in/out/enable; words read land in a FIFO
`timescale 1ns/1ns
`default_nettype none
// Contract
// - 12-bit program counter holds next fetch address, increments, clears on reset
// - All twelve counter bits share the address pins with port select and table address
// - True branch loads 12-bit absolute target, otherwise counter increments
// - Return stack is 12 bits wide and four entries deep
// - Push stores low twelve accumulator bits; pop returns head to accumulator
// - Table read and write occupy one stack level while executing
// - Overflow drops deepest entry; over-pop duplicates bottom entry upward
// - Status holds overflow, saturation, irq mask, aux select, page select
// - Status save leaves status intact; direct save forced to page one
// - Status restore reloads all but irq mask, from current page
// - Mask reads one when disabled; unmask clears, mask and entry set
// - Overflow flag set by accumulator overflow; branch-on-overflow tests and clears
// - Set-saturation writes one, clear-saturation writes zero
// - Aux select bit picks register zero or one; loaded by two ops
// - Page select zero gives first 128 words, one the 16 words at 0x80 to 0x8F
// - Data bus high impedance except while write strobe low
// - Eight 16-bit input ports and eight 16-bit output ports
// - Read strobe only for input; write strobe only for output and table write
// - Port transfers put port on low three bits, upper bits zero
// - Table write always strobes and drives data, whatever the target
// - Table ops prefetch, discard, then refetch the following instruction
// - Fetch, write and read strobes never active together
// - Fetch strobe active every cycle without write or read strobe
// - Reset starts fetching at 0, interrupt entry at 2
module pfb_top (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire pfb_pkg::pfb_op_t cmd_op_i,
  output logic cmd_ready_o,
  input wire logic [pfb_pkg::PC_W-1:0] cmd_target_i,
  input wire logic cmd_cond_i,
  input wire logic [pfb_pkg::DATA_W-1:0] cmd_acc_i,
  input wire logic [pfb_pkg::DATA_W-1:0] cmd_wdata_i,
  input wire logic [pfb_pkg::DATA_W-1:0] cmd_status_i,
  input wire logic cmd_bit_i,
  input wire logic [pfb_pkg::OFS_W-1:0] cmd_offset_i,
  input wire logic [pfb_pkg::RAM_AW-1:0] cmd_ind_addr_i,
  input wire logic acc_ovf_i,
  output logic [pfb_pkg::PC_W-1:0] prog_addr_o,
  output logic program_fetch_strobe_n_o,
  output logic write_strobe_n_o,
  output logic input_read_strobe_n_o,
  input wire logic [pfb_pkg::DATA_W-1:0] data_i,
  output logic [pfb_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o,
  output logic [pfb_pkg::DATA_W-1:0] instr_o,
  output logic instr_valid_o,
  output logic [pfb_pkg::PC_W-1:0] acc_pop_o,
  output logic [pfb_pkg::DATA_W-1:0] status_word_o,
  output logic [pfb_pkg::RAM_AW-1:0] ram_addr_o,
  output logic [pfb_pkg::DATA_W-1:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i
);
  import pfb_pkg::*;

  function automatic logic is_tbl(input pfb_op_t op);
    return (op == OP_TABLE_READ_OP) || (op == OP_TABLE_WRITE_OP);
  endfunction : is_tbl

  function automatic logic [DATA_W-1:0] pack_status(input logic ov, input logic saturation_mode_bit,
                                                    input logic irq_mask_bit, input logic aux_select_bit,
                                                    input logic dp);
    logic [DATA_W-1:0] w;
    w = SW_UNUSED;
    w[SW_OV] = ov;
    w[SW_OVM] = saturation_mode_bit;
    w[SW_IRQ_MASK_BIT] = irq_mask_bit;
    w[SW_ARP] = aux_select_bit;
    w[SW_DP] = dp;
    return w;
  endfunction : pack_status

  pfb_state_t state_reg;
  pfb_state_t state_next;
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_next;
  logic [PC_W-1:0] stack_reg [STK_DEPTH];
  logic [PC_W-1:0] stack_head;
  logic [PC_W-1:0] push_val;
  logic [PORT_W-1:0] port_reg;
  logic [PC_W-1:0] tbl_addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic acc_exceeded_flag_reg;
  logic saturation_mode_bit_reg;
  logic irq_mask_bit_reg;
  logic aux_select_bit_reg;
  logic ram_page_select_reg;
  logic [DATA_W-1:0] status_save_reg;
  logic [RAM_AW-1:0] ram_addr_reg;
  logic [PC_W-1:0] acc_pop_reg;
  logic [DATA_W-1:0] instr_reg;
  logic instr_valid_reg;
  logic take;
  logic needs_fifo;
  logic do_push;
  logic do_pop;
  logic fetch_now;

  pfb_stream_if #(.WIDTH(DATA_W)) rd_in ();
  pfb_stream_if #(.WIDTH(DATA_W)) rd_out ();

  pfb_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .in_s(rd_in.snk),
    .out_s(rd_out.src)
  );

  // Input and table-read words queue for the core
  assign rd_in.valid = (state_reg == ST_IN) || (state_reg == ST_TRD);
  assign rd_in.data = data_i;
  assign rd_data_o = rd_out.data;
  assign rd_valid_o = rd_out.valid;
  assign rd_out.ready = rd_ready_i;

  // Full FIFO stalls reads before any strobe goes out
  assign needs_fifo = (cmd_op_i == OP_IN) || (cmd_op_i == OP_TABLE_READ_OP);
  assign cmd_ready_o = (state_reg == ST_RUN) && (!needs_fifo || rd_in.ready);
  assign take = cmd_valid_i && cmd_ready_o;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (take) begin
          case (cmd_op_i)
            OP_IN: state_next = ST_IN;
            OP_OUT: state_next = ST_OUT;
            OP_TABLE_READ_OP: state_next = ST_TRD;
            OP_TABLE_WRITE_OP: state_next = ST_TWR;
            default: state_next = ST_RUN;
          endcase
        end
      end
      ST_TRD, ST_TWR: state_next = ST_REF;
      default: state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Strobes decode from one-hot state, so they can never overlap
  assign input_read_strobe_n_o = (state_reg != ST_IN);
  assign write_strobe_n_o = !((state_reg == ST_OUT) || (state_reg == ST_TWR));
  assign program_fetch_strobe_n_o = !input_read_strobe_n_o || !write_strobe_n_o;
  assign fetch_now = !program_fetch_strobe_n_o;
  assign data_oe_o = !write_strobe_n_o;
  assign data_o = wdata_reg;

  always_comb begin
    case (state_reg)
      ST_IN, ST_OUT: prog_addr_o = {{(PC_W-PORT_W){1'b0}}, port_reg};
      ST_TRD, ST_TWR: prog_addr_o = tbl_addr_reg;
      ST_REF: prog_addr_o = stack_head;
      default: prog_addr_o = pc_reg;
    endcase
  end

  always_comb begin
    pc_next = pc_reg + PC_STEP;
    case (cmd_op_i)
      OP_BRANCH: pc_next = cmd_cond_i ? cmd_target_i : pc_reg + PC_STEP;
      OP_BRANCH_OV: pc_next = acc_exceeded_flag_reg ? cmd_target_i : pc_reg + PC_STEP;
      OP_CALL: pc_next = cmd_target_i;
      OP_RET: pc_next = stack_head;
      OP_INTR: pc_next = INTR_VEC;
      OP_TABLE_READ_OP, OP_TABLE_WRITE_OP: pc_next = pc_reg;
      default: pc_next = pc_reg + PC_STEP;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pc_reg <= RESET_VEC;
    end else if (take) begin
      pc_reg <= pc_next;
    end else if (state_reg == ST_REF) begin
      pc_reg <= stack_head + PC_STEP;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      port_reg <= '0;
      tbl_addr_reg <= '0;
      wdata_reg <= '0;
    end else if (take) begin
      port_reg <= cmd_target_i[PORT_W-1:0];
      tbl_addr_reg <= cmd_acc_i[PC_W-1:0];
      wdata_reg <= cmd_wdata_i;
    end
  end

  // Return stack
  assign stack_head = stack_reg[0];
  assign do_push = take && (cmd_op_i inside {OP_PUSH, OP_CALL, OP_INTR, OP_TABLE_READ_OP, OP_TABLE_WRITE_OP});
  assign do_pop = (take && (cmd_op_i inside {OP_POP, OP_RET})) || (state_reg == ST_REF);
  assign push_val = (cmd_op_i == OP_PUSH) ? cmd_acc_i[PC_W-1:0] : pc_reg;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < STK_DEPTH; i++) begin
        stack_reg[i] <= '0;
      end
    end else if (do_push) begin
      stack_reg[0] <= push_val;
      for (int i = 1; i < STK_DEPTH; i++) begin
        stack_reg[i] <= stack_reg[i-1];
      end
    end else if (do_pop) begin
      // Bottom keeps its value, so over-pops copy it upward
      for (int i = 0; i < STK_DEPTH - 1; i++) begin
        stack_reg[i] <= stack_reg[i+1];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      acc_pop_reg <= '0;
    end else if (take && cmd_op_i == OP_POP) begin
      acc_pop_reg <= stack_head;
    end
  end
  assign acc_pop_o = acc_pop_reg;

  // Status bits
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      acc_exceeded_flag_reg <= 1'b0;
    end else if (acc_ovf_i) begin
      acc_exceeded_flag_reg <= 1'b1;
    end else if (take && cmd_op_i == OP_BRANCH_OV) begin
      acc_exceeded_flag_reg <= 1'b0;
    end else if (take && cmd_op_i == OP_LST) begin
      acc_exceeded_flag_reg <= cmd_status_i[SW_OV];
    end
  end

  // Cleared at reset so the bit is never unknown
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      saturation_mode_bit_reg <= 1'b0;
    end else if (take && cmd_op_i == OP_SET_SATURATION_OP) begin
      saturation_mode_bit_reg <= 1'b1;
    end else if (take && cmd_op_i == OP_CLEAR_SATURATION_OP) begin
      saturation_mode_bit_reg <= 1'b0;
    end else if (take && cmd_op_i == OP_LST) begin
      saturation_mode_bit_reg <= cmd_status_i[SW_OVM];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_mask_bit_reg <= 1'b1;
    end else if (take && (cmd_op_i == OP_IRQ_MASK_OP || cmd_op_i == OP_INTR)) begin
      irq_mask_bit_reg <= 1'b1;
    end else if (take && cmd_op_i == OP_IRQ_UNMASK_OP) begin
      irq_mask_bit_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      aux_select_bit_reg <= 1'b0;
    end else if (take && cmd_op_i == OP_ARP_LOAD) begin
      aux_select_bit_reg <= cmd_bit_i;
    end else if (take && cmd_op_i == OP_LST) begin
      aux_select_bit_reg <= cmd_status_i[SW_ARP];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ram_page_select_reg <= 1'b0;
    end else if (take && cmd_op_i == OP_PAGE_LOAD) begin
      ram_page_select_reg <= cmd_bit_i;
    end else if (take && cmd_op_i == OP_LST) begin
      ram_page_select_reg <= cmd_status_i[SW_DP];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      status_save_reg <= '0;
      ram_addr_reg <= '0;
    end else if (take) begin
      status_save_reg <= pack_status(acc_exceeded_flag_reg, saturation_mode_bit_reg,
                                     irq_mask_bit_reg, aux_select_bit_reg,
                                     ram_page_select_reg);
      case (cmd_op_i)
        OP_SST_DIR: ram_addr_reg <= PAGE1_BASE | {4'h0, cmd_offset_i[3:0] & PAGE1_MASK};
        OP_SST_IND: ram_addr_reg <= cmd_ind_addr_i;
        OP_LST: ram_addr_reg <= ram_page_select_reg ? (PAGE1_BASE | {4'h0, cmd_offset_i[3:0]})
                                                    : {1'b0, cmd_offset_i};
        default: ram_addr_reg <= ram_addr_reg;
      endcase
    end
  end
  assign status_word_o = status_save_reg;
  assign ram_addr_o = ram_addr_reg;

  // Dummy prefetch of a table op is not handed on
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      instr_reg <= '0;
      instr_valid_reg <= 1'b0;
    end else begin
      instr_valid_reg <= fetch_now && (state_reg == ST_REF
                         || (state_reg == ST_RUN && !(take && is_tbl(cmd_op_i))));
      if (fetch_now && state_reg != ST_TRD) begin
        instr_reg <= data_i;
      end
    end
  end
  assign instr_o = instr_reg;
  assign instr_valid_o = instr_valid_reg;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_strobe_excl: assert property ($onehot0({!program_fetch_strobe_n_o,
      !write_strobe_n_o, !input_read_strobe_n_o}))
    else $error("bus strobes overlap");
  a_fetch_every: assert property (program_fetch_strobe_n_o ==
      (!write_strobe_n_o || !input_read_strobe_n_o))
    else $error("fetch strobe wrong");
  a_pc_clear: assert property (@(posedge core_clk_i) disable iff (1'b0)
      !rst_n_i |=> pc_reg == RESET_VEC)
    else $error("pc not cleared by reset");
  a_pc_step: assert property (take && cmd_op_i == OP_NOP |=>
      pc_reg == $past(pc_reg) + PC_STEP)
    else $error("pc did not increment");
  a_branch_load: assert property (take && cmd_op_i == OP_BRANCH && cmd_cond_i |=>
      pc_reg == $past(cmd_target_i))
    else $error("branch target not loaded");
  a_bus_drive: assert property (data_oe_o |-> !write_strobe_n_o && data_o == wdata_reg)
    else $error("bus driven outside write");
  a_port_zero: assert property (!input_read_strobe_n_o || state_reg == ST_OUT |->
      prog_addr_o[PC_W-1:PORT_W] == '0)
    else $error("port address upper bits set");
  a_intr_entry: assert property (take && cmd_op_i == OP_INTR |=>
      pc_reg == INTR_VEC && irq_mask_bit_reg && stack_head == $past(pc_reg))
    else $error("interrupt entry wrong");
  a_mask_keep: assert property (take && cmd_op_i == OP_LST |=>
      $stable(irq_mask_bit_reg))
    else $error("restore changed mask");
  a_tbl_refetch: assert property (take && is_tbl(cmd_op_i) |-> ##2
      (state_reg == ST_REF && prog_addr_o == $past(pc_reg, 2)) ##1 pc_reg == $past(pc_reg, 3) + PC_STEP)
    else $error("table refetch wrong");
  a_ov_clear: assert property (take && cmd_op_i == OP_BRANCH_OV && !acc_ovf_i |=>
      !acc_exceeded_flag_reg)
    else $error("overflow flag not cleared");

  c_input: cover property (state_reg == ST_IN ##1 rd_valid_o);
  c_output: cover property (state_reg == ST_OUT);
  c_tbl_write: cover property (state_reg == ST_TWR ##1 state_reg == ST_REF);
  c_overpop: cover property (take && cmd_op_i == OP_POP [*5]);
endmodule : pfb_top
`default_nettype wire

// [testbench/pfb_bus_model.sv]
// Purpose: Program memory and port peripherals on the far side of the bus
// Assumes: Words are ready within the strobe cycle
// Notes: A released bus shows the inverse of the last word, never a stale copy
`timescale 1ns/1ns
`default_nettype none
module pfb_bus_model (
  input wire logic core_clk_i,
  input wire logic [pfb_pkg::PC_W-1:0] prog_addr_i,
  input wire logic fetch_n_i,
  input wire logic we_n_i,
  input wire logic rd_n_i,
  input wire logic [pfb_pkg::DATA_W-1:0] data_i,
  output logic [pfb_pkg::DATA_W-1:0] data_o,
  output logic [pfb_pkg::PC_W-1:0] wr_addr_o,
  output logic [pfb_pkg::DATA_W-1:0] wr_data_o
);
  import pfb_pkg::*;
  logic [DATA_W-1:0] last_q = 16'h0000;
  // Memory words tagged A, port words tagged B, so a wrong strobe shows
  always_comb begin
    if (!fetch_n_i) data_o = {4'hA, prog_addr_i};
    else if (!rd_n_i) data_o = {4'hB, prog_addr_i};
    else data_o = ~last_q;
  end
  always @(posedge core_clk_i) begin
    if (!fetch_n_i || !rd_n_i) last_q <= data_o;
    if (!we_n_i) begin
      wr_addr_o <= prog_addr_i;
      wr_data_o <= data_i;
    end
  end
endmodule : pfb_bus_model
`default_nettype wire

// [testbench/testbench.sv]
// Purpose: Self-checking bench for the program flow and bus block
// Assumes: One command in flight at a time
// Notes: Operands ride with each command; acc also seeds data and status
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pfb_pkg::*;
  logic clk, rst_n, cv, cr, cond, cbit, ovf, rrdy, rval, iv, fn, wn, rn, oe;
  pfb_op_t op;
  logic [11:0] tgt, pa, ap, wa;
  logic [15:0] acc, wd, st, sw, ddo, mdo, bus, rdd, ins, mwd;
  logic [6:0] ofs;
  logic [7:0] ia, ra;
  int miscompares = 0;
  int n_tests = 0;
  int k;
  wire logic [3:0] strb = {fn, wn, rn, oe};
  assign bus = oe ? ddo : mdo;

  pfb_top u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .cmd_valid_i(cv), .cmd_op_i(op), .cmd_ready_o(cr),
    .cmd_target_i(tgt), .cmd_cond_i(cond), .cmd_acc_i(acc), .cmd_wdata_i(wd), .cmd_status_i(st),
    .cmd_bit_i(cbit), .cmd_offset_i(ofs), .cmd_ind_addr_i(ia), .acc_ovf_i(ovf), .prog_addr_o(pa),
    .program_fetch_strobe_n_o(fn), .write_strobe_n_o(wn), .input_read_strobe_n_o(rn), .data_i(bus),
    .data_o(ddo), .data_oe_o(oe), .instr_o(ins), .instr_valid_o(iv), .acc_pop_o(ap),
    .status_word_o(sw), .ram_addr_o(ra), .rd_data_o(rdd), .rd_valid_o(rval), .rd_ready_i(rrdy));
  pfb_bus_model u_mem (.core_clk_i(clk), .prog_addr_i(pa), .fetch_n_i(fn), .we_n_i(wn), .rd_n_i(rn),
    .data_i(bus), .data_o(mdo), .wr_addr_o(wa), .wr_data_o(mwd));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic step;
    @(posedge clk);
    #1;
  endtask : step

  // Returns 1 ns into the cycle after the taking edge
  task automatic go(input pfb_op_t o, input logic [11:0] t, input logic [15:0] a);
    @(posedge clk);
    op <= o;
    tgt <= t;
    acc <= a;
    wd <= ~a;
    st <= a;
    cond <= a[0];
    cbit <= a[0];
    ofs <= t[6:0];
    ia <= t[7:0];
    cv <= 1'b1;
    #1;
    for (k = 0; k < 40 && cr !== 1'b1; k++) step();
    @(posedge clk);
    cv <= 1'b0;
    #1;
  endtask : go

  task automatic sw_is(input logic [15:0] e);
    go(OP_NOP, 12'h000, 16'h0000);
    chk("sw", sw, e);
  endtask : sw_is

  task automatic pull(input logic [15:0] e);
    for (k = 0; k < 20 && rval !== 1'b1; k++) step();
    chk("rd", rdd, e);
    step();
  endtask : pull

  task automatic t_reset;
    chk("strb", 16'(strb), 16'h0006);
    chk("pa", 16'(pa), 16'h0000);
    go(OP_NOP, 12'h000, 16'h0000);
    chk("pa", 16'(pa), 16'h0001);
    sw_is(16'h3EFE);
  endtask : t_reset

  task automatic t_branch;
    go(OP_BRANCH, 12'h5A5, 16'h0001);
    chk("pa", 16'(pa), 16'h05A5);
    go(OP_BRANCH, 12'h123, 16'h0000);
    chk("pa", 16'(pa), 16'h05A6);
    go(OP_BRANCH, 12'h200, 16'h0001);
    go(OP_CALL, 12'h300, 16'h0000);
    chk("pa", 16'(pa), 16'h0300);
    go(OP_RET, 12'h000, 16'h0000);
    chk("pa", 16'(pa), 16'h0200);
  endtask : t_branch

  task automatic t_status;
    pfb_op_t ol[8] = '{OP_IRQ_UNMASK_OP, OP_SET_SATURATION_OP, OP_ARP_LOAD, OP_PAGE_LOAD, OP_IRQ_MASK_OP, OP_CLEAR_SATURATION_OP, OP_PAGE_LOAD, OP_LST};
    logic [15:0] al[8] = '{16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'hC101};
    logic [15:0] el[8] = '{16'h1EFE, 16'h5EFE, 16'h5FFE, 16'h5FFF, 16'h7FFF, 16'h3FFF, 16'h3FFE, 16'hFFFF};
    for (int i = 0; i < 8; i++) begin
      go(ol[i], 12'h025, al[i]);
      sw_is(el[i]);
    end
    chk("ra", 16'(ra), 16'h0025);
    go(OP_LST, 12'h025, 16'hC101);
    chk("ra", 16'(ra), 16'h0085);
    go(OP_SST_DIR, 12'h013, 16'h0000);
    chk("ra", 16'(ra), 16'h0083);
    sw_is(16'hFFFF);
    go(OP_SST_IND, 12'h03C, 16'h0000);
    chk("ra", 16'(ra), 16'h003C);
  endtask : t_status

  task automatic t_ovf;
    go(OP_BRANCH_OV, 12'h0F0, 16'h0000);
    chk("pa", 16'(pa), 16'h00F0);
    sw_is(16'h7FFF);
    go(OP_BRANCH_OV, 12'h0AA, 16'h0000);
    chk("pa", 16'(pa), 16'h00F2);
    @(posedge clk);
    ovf <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
    sw_is(16'hFFFF);
    go(OP_IRQ_UNMASK_OP, 12'h000, 16'h0000);
    go(OP_INTR, 12'h000, 16'h0000);
    chk("pa", 16'(pa), 16'h0002);
    sw_is(16'hFFFF);
  endtask : t_ovf

  // Five pushes into four levels: the first is lost, the bottom repeats
  task automatic t_stack;
    for (int i = 1; i <= 5; i++) go(OP_PUSH, 12'h000, {4'hF, 12'(i * 12'h111)});
    for (int i = 5; i >= 1; i--) begin
      go(OP_POP, 12'h000, 16'h0000);
      chk("pop", 16'(ap), 16'((i > 1 ? i : 2) * 12'h111));
    end
  endtask : t_stack

  task automatic t_out;
    go(OP_OUT, 12'hFF5, 16'h3C5A);
    chk("strb", 16'(strb), 16'h000B);
    chk("pa", 16'(pa), 16'h0005);
    chk("do", ddo, 16'hC3A5);
    step();
    chk("wa", 16'(wa), 16'h0005);
    chk("wd", mwd, 16'hC3A5);
    chk("strb", 16'(strb), 16'h0006);
  endtask : t_out

  task automatic t_table;
    go(OP_BRANCH, 12'h400, 16'h0001);
    go(OP_PUSH, 12'h000, 16'h0777);
    go(OP_TABLE_WRITE_OP, 12'h000, 16'h0ABC);
    chk("strb", 16'(strb), 16'h000B);
    chk("pa", 16'(pa), 16'h0ABC);
    chk("do", ddo, 16'hF543);
    chk("iv", 16'(iv), 16'h0000);
    step();
    chk("pa", 16'(pa), 16'h0401);
    step();
    chk("ins", ins, 16'hA401);
    go(OP_TABLE_READ_OP, 12'h000, 16'h07C9);
    chk("pa", 16'(pa), 16'h07C9);
    chk("strb", 16'(strb), 16'h0006);
    pull(16'hA7C9);
    go(OP_POP, 12'h000, 16'h0000);
    chk("pop", 16'(ap), 16'h0777);
  endtask : t_table

  // Core side stops taking words until the buffer refuses a ninth input
  task automatic t_in_fifo;
    @(posedge clk);
    rrdy <= 1'b0;
    for (int p = 0; p < 8; p++) begin
      go(OP_IN, {9'h1FF, 3'(p)}, 16'h0000);
      chk("strb", 16'(strb), 16'h000C);
      chk("pa", 16'(pa), 16'(p));
    end
    @(posedge clk);
    op <= OP_IN;
    repeat (3) step();
    chk("cr", 16'(cr), 16'h0000);
    @(posedge clk);
    rrdy <= 1'b1;
    #1;
    for (int p = 0; p < 8; p++) pull(16'hB000 + 16'(p));
    chk("rv", 16'(rval), 16'h0000);
  endtask : t_in_fifo

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  initial begin
    {rst_n, cv, cond, cbit, ovf} = 5'h00;
    {tgt, acc, wd, st, ofs, ia} = '0;
    op = OP_NOP;
    rrdy = 1'b1;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_reset();
    t_branch();
    t_status();
    t_ovf();
    t_stack();
    t_out();
    t_table();
    t_in_fifo();
    stop_test();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
